/* logic/rtw_pkg.sv */
// Purpose: constants shared by the two-wire clock-chip host controller
// Assumes: 50 MHz mclk, 250 kHz serial clock
// Notes: cycle counts derive from times and the clock rate
package rtw_pkg;

   // clock rates and derived quarter-bit length
   localparam int MCLK_HZ = 50_000_000;
   localparam int CLK_NS = 20;
   localparam int SCL_HZ = 250_000;
   localparam logic [11:0] QUARTER_CYC = 12'(MCLK_HZ / (4 * SCL_HZ));

   // least idle time after a stop before a new start
   localparam int STOP_GAP_NS = 62_000;
   localparam logic [11:0] STOP_GAP_CYC =
      12'((STOP_GAP_NS + CLK_NS - 1) / CLK_NS);

   // longest allowed access from first start to stop
   localparam int ACCESS_MS = 500;
   localparam int ACCESS_CYC = ACCESS_MS * (MCLK_HZ / 1000);

   // byte-level command codes on the user port
   localparam logic [1:0] CMD_START = 2'h0;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_READ = 2'h2;
   localparam logic [1:0] CMD_STOP = 2'h3;

   // device addressing and second-byte layout
   localparam logic [6:0] RTC_ADDR = 7'h32;
   localparam logic RW_READ = 1'h1;
   localparam logic RW_WRITE = 1'h0;
   localparam int PTR_MSB = 7;
   localparam int PTR_LSB = 4;
   localparam int FMT_MSB = 3;
   localparam int FMT_LSB = 0;
   localparam logic [3:0] FMT_PLAIN = 4'h0;
   localparam logic [3:0] FMT_READ_NOW = 4'h4;
   localparam logic [3:0] PTR_DEFAULT = 4'hF;

   // bits per byte, counting down to the acknowledge slot
   localparam logic [3:0] BITS_FIRST = 4'h8;

endpackage : rtw_pkg

/* logic/rtw_host.sv */
// Purpose: host-side master for the two-wire port of a real-time clock
// Assumes: open-drain pins resolved outside; ce high for normal running
// Notes: byte-level commands; user composes address and pointer bytes
`timescale 1ns/1ns
module rtw_host
   import rtw_pkg::*;
#(
   parameter int ACC_LIMIT = ACCESS_CYC
) (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // command request
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_code,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_ack,
   output logic cmd_ready,
   // command answer
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_acked,
   // access status
   output logic in_access,
   output logic acc_overrun,
   // serial clock pin, open drain
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   // serial data pin, open drain
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);

   localparam int ACC_W = $clog2(ACC_LIMIT + 1);
   localparam logic [ACC_W-1:0] ACC_LAST = ACC_W'(ACC_LIMIT - 1);
   localparam logic [11:0] Q_LAST = QUARTER_CYC - 12'h001;
   localparam logic [11:0] GAP_LAST = STOP_GAP_CYC - 12'h001;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_BIT = 3'b010,
      ST_STOP = 3'b011,
      ST_GAP = 3'b100
   } rtw_state_e;

   typedef struct packed {
      rtw_state_e st;
      logic [1:0] ph;
      logic [11:0] cnt;
      logic [3:0] bidx;
      logic [7:0] sh;
      logic [1:0] code;
      logic ackbit;
      logic rdy;
      logic rsp_valid;
      logic [7:0] rsp_data;
      logic rsp_acked;
      logic in_acc;
      logic overrun;
      logic [ACC_W-1:0] acc_t;
      logic scl_oe;
      logic sda_oe;
      logic pin_lo;
      logic sda_m;
      logic sda_s;
      logic scl_m;
      logic scl_s;
   } rtw_reg_s;

   localparam rtw_reg_s RST_VAL = '{
      st: ST_IDLE,
      ph: 2'h0,
      cnt: 12'h000,
      bidx: 4'h0,
      sh: 8'h00,
      code: 2'h0,
      ackbit: 1'b0,
      rdy: 1'b1,
      rsp_valid: 1'b0,
      rsp_data: 8'h00,
      rsp_acked: 1'b0,
      in_acc: 1'b0,
      overrun: 1'b0,
      acc_t: '0,
      scl_oe: 1'b0,
      sda_oe: 1'b0,
      pin_lo: 1'b0,
      sda_m: 1'b1,
      sda_s: 1'b1,
      scl_m: 1'b1,
      scl_s: 1'b1
   };

   rtw_reg_s q;
   rtw_reg_s d;

   // quarter timer expires; phase 1 also waits for SCL to read high
   function automatic logic quarter_done(input logic [11:0] cnt,
                                         input logic [1:0] ph,
                                         input logic scl_hi);
      quarter_done = (cnt == Q_LAST) && (ph != 2'h1 || scl_hi);
   endfunction : quarter_done

   // next state of all registers
   always_comb begin
      d = q;
      if (ce) begin
         d.rsp_valid = 1'b0;
         // pins pass two flops before any logic looks at them
         d.sda_m = sda_i;
         d.sda_s = q.sda_m;
         d.scl_m = scl_i;
         d.scl_s = q.scl_m;
         // access budget counted from the first start only
         if (q.in_acc && !q.overrun) begin
            if (q.acc_t == ACC_LAST) begin
               d.overrun = 1'b1;
            end else begin
               d.acc_t = q.acc_t + 1'b1;
            end
         end
         // quarter-bit timer, held at its end while SCL is stretched
         if (q.st != ST_IDLE && q.st != ST_GAP) begin
            if (quarter_done(q.cnt, q.ph, q.scl_s)) begin
               d.cnt = 12'h000;
               d.ph = q.ph + 2'h1;
            end else if (q.cnt != Q_LAST) begin
               d.cnt = q.cnt + 12'h001;
            end
         end
         case (q.st)
            ST_IDLE: begin
               if (cmd_valid && q.rdy) begin
                  d.rdy = 1'b0;
                  d.cnt = 12'h000;
                  d.ph = 2'h0;
                  d.code = cmd_code;
                  d.sh = cmd_data;
                  d.ackbit = cmd_ack;
                  d.bidx = BITS_FIRST;
                  case (cmd_code)
                     CMD_START: begin
                        d.st = ST_START;
                        // a repeated start keeps the running budget
                        if (!q.in_acc) begin
                           d.acc_t = '0;
                           d.overrun = 1'b0;
                        end
                        d.in_acc = 1'b1;
                     end
                     CMD_STOP: d.st = ST_STOP;
                     default: begin
                        d.st = ST_BIT;
                     end
                  endcase
               end
            end
            ST_START: begin
               // release SDA, raise SCL, pull SDA low, pull SCL low
               case (q.ph)
                  2'h0: d.sda_oe = 1'b0;
                  2'h1: d.scl_oe = 1'b0;
                  2'h2: d.sda_oe = 1'b1;
                  default: begin
                     d.scl_oe = 1'b1;
                     if (quarter_done(q.cnt, q.ph, q.scl_s)) begin
                        d.st = ST_IDLE;
                        d.rdy = 1'b1;
                        d.rsp_valid = 1'b1;
                        d.rsp_acked = 1'b0;
                     end
                  end
               endcase
            end
            ST_BIT: begin
               case (q.ph)
                  2'h0: begin
                     d.scl_oe = 1'b1;
                     if (q.code == CMD_WRITE) begin
                        // data MSB first, then let go for the ack slot
                        d.sda_oe = (q.bidx != 4'h0) && !q.sh[7];
                     end else begin
                        // acknowledge, or withhold it after the last byte
                        d.sda_oe = (q.bidx == 4'h0) && q.ackbit;
                     end
                  end
                  2'h1: d.scl_oe = 1'b0;
                  2'h2: begin
                     if (quarter_done(q.cnt, q.ph, q.scl_s)) begin
                        if (q.bidx != 4'h0) begin
                           d.sh = {q.sh[6:0], q.sda_s};
                        end else begin
                           d.rsp_acked = !q.sda_s;
                        end
                     end
                  end
                  default: begin
                     d.scl_oe = 1'b1;
                     if (quarter_done(q.cnt, q.ph, q.scl_s)) begin
                        if (q.bidx == 4'h0) begin
                           // drop a held acknowledge a quarter after the fall
                           d.sda_oe = 1'b0;
                           d.st = ST_IDLE;
                           d.rdy = 1'b1;
                           d.rsp_valid = 1'b1;
                           d.rsp_data = q.sh;
                        end else begin
                           d.bidx = q.bidx - 4'h1;
                        end
                     end
                  end
               endcase
            end
            ST_STOP: begin
               // pull SDA low, raise SCL, release SDA
               case (q.ph)
                  2'h0: begin
                     d.sda_oe = 1'b1;
                     d.scl_oe = 1'b1;
                  end
                  2'h1: d.scl_oe = 1'b0;
                  2'h2: d.sda_oe = 1'b0;
                  default: begin
                     if (quarter_done(q.cnt, q.ph, q.scl_s)) begin
                        d.st = ST_GAP;
                        d.cnt = 12'h000;
                        d.in_acc = 1'b0;
                     end
                  end
               endcase
            end
            ST_GAP: begin
               // bus idle time before the next start may go out
               if (q.cnt == GAP_LAST) begin
                  d.st = ST_IDLE;
                  d.rdy = 1'b1;
                  d.rsp_valid = 1'b1;
                  d.rsp_acked = 1'b0;
               end else begin
                  d.cnt = q.cnt + 12'h001;
               end
            end
            default: begin
               d = RST_VAL;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= RST_VAL;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register
   assign cmd_ready = q.rdy;
   assign rsp_valid = q.rsp_valid;
   assign rsp_data = q.rsp_data;
   assign rsp_acked = q.rsp_acked;
   assign in_access = q.in_acc;
   assign acc_overrun = q.overrun;
   assign scl_o = q.pin_lo;
   assign scl_oe = q.scl_oe;
   assign sda_o = q.pin_lo;
   assign sda_oe = q.sda_oe;

   // start edge lands while SCL is released
   a_start_scl_high: assert property (
      @(posedge mclk) disable iff (rst)
      (q.st == ST_START && q.ph == 2'h2 && q.sda_oe) |-> !q.scl_oe)
      else $error("start SDA fall without SCL high");

   // stop edge lands while SCL is released
   a_stop_scl_high: assert property (
      @(posedge mclk) disable iff (rst)
      (q.st == ST_STOP && q.ph == 2'h3) |-> (!q.scl_oe && !q.sda_oe))
      else $error("stop not held with both lines released");

   // SDA never moves while SCL is high during a bit
   a_bit_sda_steady: assert property (
      @(posedge mclk) disable iff (rst)
      (q.st == ST_BIT && q.ph == 2'h2) |-> $stable(q.sda_oe))
      else $error("SDA changed while SCL high");

   // master lets go of SDA in the slot where the device acknowledges
   a_ack_release: assert property (
      @(posedge mclk) disable iff (rst)
      (q.st == ST_BIT && q.code == CMD_WRITE && q.bidx == 4'h0
       && q.ph != 2'h0) |-> !q.sda_oe)
      else $error("SDA driven in write ack slot");

   // last read byte leaves SDA released in its ack slot
   a_last_nack: assert property (
      @(posedge mclk) disable iff (rst)
      (q.st == ST_BIT && q.code == CMD_READ && q.bidx == 4'h0
       && !q.ackbit && q.ph != 2'h0) |-> !q.sda_oe)
      else $error("acknowledge sent on final read byte");

   // no start request taken during the gap after a stop
   a_gap_blocks: assert property (
      @(posedge mclk) disable iff (rst)
      (q.st == ST_GAP) |-> !q.rdy)
      else $error("ready during post-stop gap");

   // gap lasts exactly its cycle count
   a_gap_length: assert property (
      @(posedge mclk) disable iff (rst)
      ($past(q.st) == ST_GAP && q.st == ST_IDLE)
      |-> $past(q.cnt) == GAP_LAST)
      else $error("post-stop gap cut short");

   // repeated start keeps the access budget running
   a_restart_keeps: assert property (
      @(posedge mclk) disable iff (rst)
      (q.st == ST_START && $past(q.st) == ST_IDLE && $past(q.in_acc))
      |-> q.acc_t >= $past(q.acc_t))
      else $error("repeated start reset access timer");

   // overrun raised once the budget is spent
   a_overrun_flag: assert property (
      @(posedge mclk) disable iff (rst)
      (ce && q.in_acc && !q.overrun && q.acc_t == ACC_LAST)
      |=> q.overrun)
      else $error("access overrun not flagged");

   // answer is a single-cycle pulse
   a_rsp_pulse: assert property (
      @(posedge mclk) disable iff (rst)
      (ce && q.rsp_valid) |=> !q.rsp_valid)
      else $error("answer pulse longer than one cycle");

endmodule : rtw_host

/* dv/rtw_dev_model.sv */
// Purpose: behavioural clock-chip slave on the two-wire bus
// Assumes: both wires pulled up; sda_pull high drives SDA low
// Notes: registers start at A0h plus their index
`timescale 1ns/1ns
module rtw_dev_model
   import rtw_pkg::*;
#(
   parameter int ABORT_CYC = 27000
) (
   // clock and wires
   input wire logic mclk,
   input wire logic scl,
   input wire logic sda,
   // drive and status
   output logic sda_pull,
   output logic hold
);
   logic [7:0] mem [16];
   logic [7:0] sr, obyte;
   logic [3:0] ptr, cnt;
   logic [2:0] mode, nxt;
   logic act, abt, mack;
   int tmr;

   // power-up state, pointer at its default
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 8'hA0 | 8'(i);
      {sr, obyte, cnt, mode, nxt, act, abt, mack, sda_pull, hold} = '0;
      ptr = PTR_DEFAULT;
      tmr = 0;
   end
   // start or repeated start; only a first start restarts the timer
   always @(negedge sda) if (scl === 1'b1) begin
      if (!act) begin
         tmr = 0;
         hold = 1'b1;
      end
      act = 1'b1;
      mode = 3'h1;
      cnt = 4'hF; // the start's own SCL fall wraps it to zero
      sda_pull = 1'b0;
   end
   // stop ends the access and lifts the hold
   always @(posedge sda) if (scl === 1'b1 && act) begin
      {act, abt, hold, sda_pull} = '0;
      mode = 3'h0;
      ptr = PTR_DEFAULT;
   end
   // watchdog acts like a stop but keeps the bus state
   always @(posedge mclk) if (act && !abt) begin
      tmr++;
      if (tmr >= ABORT_CYC) begin
         abt = 1'b1;
         hold = 1'b0;
         ptr = PTR_DEFAULT;
      end
   end
   // sample data bits, then the master's acknowledge
   always @(posedge scl) if (act) begin
      if (cnt < 4'h8) sr = {sr[6:0], sda};
      else if (mode == 3'h4) mack = !sda;
   end
   // shift out, acknowledge after eight bits, release after the ninth
   always @(negedge scl) if (act && mode != 3'h0) begin
      cnt++;
      if (cnt == 4'h8) begin
         sda_pull = 1'b0;
         mack = 1'b1;
         nxt = (mode == 3'h4) ? 3'h4 : 3'h0;
         if (mode == 3'h1 && sr[7:1] == RTC_ADDR) begin
            sda_pull = 1'b1;
            nxt = (sr[0] == RW_READ) ? 3'h4 : 3'h2;
         end else if (mode == 3'h2) begin
            ptr = sr[PTR_MSB:PTR_LSB];
            sda_pull = 1'b1;
            nxt = (sr[FMT_MSB:FMT_LSB] == FMT_READ_NOW) ? 3'h4 : 3'h3;
         end else if (mode == 3'h3) begin
            nxt = 3'h3;
            if (!abt) begin
               mem[ptr] = sr;
               ptr++;
               sda_pull = 1'b1;
            end
         end
      end else if (cnt == 4'h9) begin
         cnt = 4'h0;
         mode = mack ? nxt : 3'h0;
         sda_pull = 1'b0;
         if (mode == 3'h4) begin
            obyte = abt ? 8'hFF : mem[ptr];
            ptr++;
            sda_pull = !obyte[7];
         end
      end else if (mode == 3'h4) sda_pull = !obyte[7 - cnt];
   end
endmodule : rtw_dev_model

/* dv/rtw_host_test.sv */
// Purpose: self-checking bench for the two-wire clock-chip host
// Assumes: behavioural device on pulled-up wires
// Notes: access and abort limits shortened for run time
`timescale 1ns/1ns
module rtw_host_test
   import rtw_pkg::*;
;
   localparam int ACC = 11000;
   localparam int ABT = 12000;
   localparam logic [7:0] AW = {RTC_ADDR, RW_WRITE};
   localparam logic [7:0] AR = {RTC_ADDR, RW_READ};
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   logic [1:0] cmd_code = CMD_START;
   logic [7:0] cmd_data = 8'h00;
   logic cmd_ack = 1'b0;
   logic ce = 1'b1;
   logic cmd_ready, rsp_valid, rsp_acked, in_access, acc_overrun;
   logic [7:0] rsp_data;
   logic scl_oe, sda_oe, pull, hold, scl_w, sda_w, scl_o, sda_o;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;

   // open-drain wires with pull-ups
   assign scl_w = scl_oe ? scl_o : 1'b1;
   assign sda_w = (sda_oe ? sda_o : 1'b1) && !pull;

   rtw_host #(.ACC_LIMIT(ACC)) u_rtw_host (.mclk(mclk), .rst(rst),
      .ce(ce), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_data(cmd_data), .cmd_ack(cmd_ack), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_acked(rsp_acked),
      .in_access(in_access), .acc_overrun(acc_overrun), .scl_i(scl_w),
      .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe(sda_oe));
   rtw_dev_model #(.ABORT_CYC(ABT)) u_rtw_dev_model (.mclk(mclk),
      .scl(scl_w), .sda(sda_w), .sda_pull(pull), .hold(hold));

   always #10 mclk = ~mclk;

   task automatic finish_test;
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test

   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t bit %b not %b", $time, got, exp);
      end
   endtask : chk_bit

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t byte %h not %h", $time, got, exp);
      end
   endtask : chk_byte

   // one command: hold until taken, then await its answer
   task automatic op(input logic [1:0] c, input logic [7:0] d, input logic a);
      int n;
      n = 0;
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_data <= d;
      cmd_ack <= a;
      do @(posedge mclk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      do begin
         @(posedge mclk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 20000);
      chk_bit(rsp_valid, 1'b1);
   endtask : op

   task automatic wr(input logic [7:0] d, input logic ea);
      op(CMD_WRITE, d, 1'b0);
      chk_bit(rsp_acked, ea);
   endtask : wr

   task automatic rd(input logic [7:0] e, input logic a);
      op(CMD_READ, 8'h00, a);
      chk_byte(rsp_data, e);
   endtask : rd

   // write E, F and the wrapped 0 in one access
   task automatic s_write;
      op(CMD_START, 8'h00, 1'b0);
      chk_bit(hold, 1'b1);
      wr(AW, 1'b1);
      wr(8'hE0, 1'b1);
      wr(8'h55, 1'b1);
      wr(8'hAA, 1'b1);
      wr(8'h33, 1'b1);
      chk_bit(acc_overrun, 1'b0);
      op(CMD_STOP, 8'h00, 1'b0);
      chk_bit(hold, 1'b0);
      chk_bit(in_access, 1'b0);
   endtask : s_write

   // pointer write, repeated start, read across the wrap
   task automatic s_read_rs;
      op(CMD_START, 8'h00, 1'b0);
      wr(AW, 1'b1);
      wr(8'hF0, 1'b1);
      op(CMD_START, 8'h00, 1'b0);
      wr(AR, 1'b1);
      rd(8'hAA, 1'b1);
      rd(8'h33, 1'b0);
      op(CMD_STOP, 8'h00, 1'b0);
   endtask : s_read_rs

   // foreign address refused, then direct read from the default
   task automatic s_direct;
      op(CMD_START, 8'h00, 1'b0);
      wr({7'h33, RW_WRITE}, 1'b0);
      op(CMD_START, 8'h00, 1'b0);
      wr(AR, 1'b1);
      rd(8'hAA, 1'b0);
      op(CMD_STOP, 8'h00, 1'b0);
   endtask : s_direct

   // format 4h sends data straight after the pointer byte
   task automatic s_read_now;
      op(CMD_START, 8'h00, 1'b0);
      wr(AW, 1'b1);
      wr(8'hE4, 1'b1);
      rd(8'h55, 1'b0);
      op(CMD_STOP, 8'h00, 1'b0);
   endtask : s_read_now

   // clock enable low in mid-byte freezes the host, pins included
   task automatic s_freeze;
      int n;
      n = 0;
      op(CMD_START, 8'h00, 1'b0);
      wr(AW, 1'b1);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_code <= CMD_WRITE;
      cmd_data <= 8'hE0;
      cmd_ack <= 1'b0;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      // SCL is released here; unfrozen it would be low again later
      repeat (3 * QUARTER_CYC / 2) @(posedge mclk);
      ce <= 1'b0;
      repeat (6 * QUARTER_CYC) @(posedge mclk);
      chk_bit(scl_oe, 1'b0);
      ce <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 20000);
      chk_bit(rsp_valid, 1'b1);
      chk_bit(rsp_acked, 1'b1);
      op(CMD_STOP, 8'h00, 1'b0);
   endtask : s_freeze

   // overlong access with a repeated start: flag, abort, refusal
   task automatic s_abort;
      int n;
      n = 0;
      op(CMD_START, 8'h00, 1'b0);
      wr(AW, 1'b1);
      op(CMD_START, 8'h00, 1'b0);
      wr(AW, 1'b1);
      wr(8'h10, 1'b1);
      while (acc_overrun !== 1'b1 && n < ACC) begin
         @(posedge mclk);
         n++;
      end
      chk_bit(acc_overrun, 1'b1);
      repeat (ABT - ACC + 500) @(posedge mclk);
      chk_bit(hold, 1'b0);
      wr(8'h77, 1'b0);
      op(CMD_STOP, 8'h00, 1'b0);
   endtask : s_abort

   // cycle ceiling against a hang
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 90000) begin
         errors++;
         $display("CHECK FAILED %0t timeout", $time);
         finish_test();
      end
   end

   // reset, then the scenarios in turn
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      s_write();
      s_read_rs();
      s_direct();
      s_read_now();
      s_freeze();
      s_abort();
      finish_test();
   end
endmodule : rtw_host_test
